/* File: inc/lpfa_pkg.sv */
// constants, register map and carrier types for the l4 port filter action block
package lpfa_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] LPFA_IDX_ACT_LOW = 10'h096;
   localparam logic [9:0] LPFA_IDX_ACT_HIGH = 10'h097;
   localparam logic [9:0] LPFA_IDX_CTRL = 10'h098;
   localparam logic [15:0] LPFA_RST_ACT = 16'h0000;
   localparam logic [15:0] LPFA_RST_CTRL = 16'h0000;
   // reserved bits 15:14 of the control register read zero
   localparam logic [15:0] LPFA_CTRL_MASK = 16'h3FFF;
   // field layout
   localparam int LPFA_NUM_FILT = 8;
   localparam int LPFA_FILT_PER_REG = 4;
   localparam int LPFA_FILT_W = 4;
   localparam int LPFA_ACT_LSB = 2;
   localparam int LPFA_PRI_LSB = 0;
   localparam int LPFA_COMP_LSB = 12;
   localparam int LPFA_PREC_LSB = 6;
   localparam int LPFA_PRIEN_LSB = 0;
   localparam int LPFA_NUM_PORTS = 6;
   // action codes
   localparam logic [1:0] LPFA_ACT_DEFAULT = 2'h0;
   localparam logic [1:0] LPFA_ACT_DROP = 2'h1;
   localparam logic [1:0] LPFA_ACT_TO_CPU = 2'h2;
   localparam logic [1:0] LPFA_ACT_NO_CPU = 2'h3;
   // compare select codes
   localparam logic [1:0] LPFA_COMP_OFF = 2'h0;
   localparam logic [1:0] LPFA_COMP_DST = 2'h1;
   localparam logic [1:0] LPFA_COMP_SRC = 2'h2;
   localparam logic [1:0] LPFA_COMP_ANY = 2'h3;
   localparam logic [1:0] LPFA_RESP_OKAY = 2'h0;
   localparam logic [1:0] LPFA_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic valid;
      logic [2:0] ingress_port;
      logic [5:0] default_ports;
      logic [7:0] src_match;
      logic [7:0] dst_match;
      logic ip_hit;
      logic [5:0] ip_ports;
      logic [1:0] ip_queue;
   } lpfa_req_type;

   typedef struct packed {
      logic valid;
      logic l4_hit;
      logic use_ip;
      logic [2:0] filter;
      logic [5:0] ports;
      logic queue_en;
      logic [1:0] queue;
   } lpfa_res_type;
endpackage : lpfa_pkg

/* File: verilog/lpfa_top.sv */
// l4 port filter action and match control register bank with frame classifier
// Notes on behaviour
// - action 00 gives the frame's default output ports
// - action 01 gives an all-zero port map, frame goes nowhere
// - action 10: non-cpu ingress goes to cpu only; cpu ingress gets defaults minus cpu
// - action 11 gives default ports with the cpu port removed
// - priority field 0..3 selects egress queue 0..3
// - low action register holds filters 0..3, four bits each, action above priority
// - high action register holds filters 4..7 in the same layout
// - compare select: off, destination, source, or either port
// - per-port bits 11:6: set means ip result wins over l4 result
// - per-port bits 5:0: set means l4 priority picks the queue
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module lpfa_top
   import lpfa_pkg::*;
#(
   parameter logic [2:0] CPU_PORT = 3'h5
) (
   input wire logic SYS_CLK_I,
   input wire logic RSTN_I,
   input wire logic [11:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [11:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   input wire lpfa_req_type FRM_REQ_I,
   output lpfa_res_type FRM_RES_O
);

   logic rst_meta_reg;
   logic rst_n_reg;

   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   // registers
   logic [15:0] act_low_reg;
   logic [15:0] act_high_reg;
   logic [15:0] ctrl_reg;

   // write channel holding
   logic aw_hold_reg;
   logic [11:0] aw_addr_reg;
   logic w_hold_reg;
   logic [15:0] w_data_reg;
   logic [1:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   function automatic logic [15:0] merge_bytes(input logic [15:0] old_v, input logic [15:0] new_v,
                                              input logic [1:0] strb);
      merge_bytes = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
   endfunction : merge_bytes

   wire logic aw_take = S_AXI_AWVALID_I && !aw_hold_reg;
   wire logic w_take = S_AXI_WVALID_I && !w_hold_reg;
   // write commits only once both halves are held and the previous response has gone
   wire logic wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;
   wire logic [9:0] wr_idx = aw_addr_reg[11:2];
   wire logic wr_aligned = (aw_addr_reg[1:0] == 2'h0);
   wire logic wr_low = wr_go && wr_aligned && (wr_idx == LPFA_IDX_ACT_LOW);
   wire logic wr_high = wr_go && wr_aligned && (wr_idx == LPFA_IDX_ACT_HIGH);
   wire logic wr_ctrl = wr_go && wr_aligned && (wr_idx == LPFA_IDX_CTRL);
   wire logic wr_hit = wr_low || wr_high || wr_ctrl;
   wire logic ar_take = S_AXI_ARVALID_I && !rvalid_reg;
   wire logic [9:0] rd_idx = S_AXI_ARADDR_I[11:2];
   wire logic rd_aligned = (S_AXI_ARADDR_I[1:0] == 2'h0);
   wire logic rd_low = rd_aligned && (rd_idx == LPFA_IDX_ACT_LOW);
   wire logic rd_high = rd_aligned && (rd_idx == LPFA_IDX_ACT_HIGH);
   wire logic rd_ctrl = rd_aligned && (rd_idx == LPFA_IDX_CTRL);
   wire logic [15:0] rd_mux = rd_low ? act_low_reg : rd_high ? act_high_reg :
                              rd_ctrl ? (ctrl_reg & LPFA_CTRL_MASK) : 16'h0000;
   wire logic rd_hit = rd_low || rd_high || rd_ctrl;

   assign S_AXI_AWREADY_O = !aw_hold_reg;
   assign S_AXI_WREADY_O = !w_hold_reg;
   assign S_AXI_BVALID_O = bvalid_reg;
   assign S_AXI_BRESP_O = bresp_reg;
   assign S_AXI_ARREADY_O = !rvalid_reg;
   assign S_AXI_RVALID_O = rvalid_reg;
   assign S_AXI_RDATA_O = rdata_reg;
   assign S_AXI_RRESP_O = rresp_reg;

   always_ff @(posedge SYS_CLK_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_hold_reg <= 1'b0;
         w_data_reg <= 16'h0000;
         w_strb_reg <= 2'h0;
      end else begin
         if (aw_take) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR_I;
         end else if (wr_go) begin
            aw_hold_reg <= 1'b0;
         end
         if (w_take) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA_I[15:0];
            w_strb_reg <= S_AXI_WSTRB_I[1:0];
         end else if (wr_go) begin
            w_hold_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= LPFA_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_hit ? LPFA_RESP_OKAY : LPFA_RESP_SLVERR;
      end else if (S_AXI_BREADY_I) begin
         bvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= LPFA_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= {16'h0000, rd_mux};
         rresp_reg <= rd_hit ? LPFA_RESP_OKAY : LPFA_RESP_SLVERR;
      end else if (S_AXI_RREADY_I) begin
         rvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         act_low_reg <= LPFA_RST_ACT;
         act_high_reg <= LPFA_RST_ACT;
         ctrl_reg <= LPFA_RST_CTRL;
      end else begin
         if (wr_low) begin
            act_low_reg <= merge_bytes(act_low_reg, w_data_reg, w_strb_reg);
         end
         if (wr_high) begin
            act_high_reg <= merge_bytes(act_high_reg, w_data_reg, w_strb_reg);
         end
         if (wr_ctrl) begin
            ctrl_reg <= merge_bytes(ctrl_reg, w_data_reg, w_strb_reg) & LPFA_CTRL_MASK;
         end
      end
   end

   // per-filter field extraction
   logic [1:0] filt_act [LPFA_NUM_FILT];
   logic [1:0] filt_pri [LPFA_NUM_FILT];

   for (genvar g = 0; g < LPFA_NUM_FILT; g++) begin : g_filt
      localparam int BASE = (g % LPFA_FILT_PER_REG) * LPFA_FILT_W;
      wire logic [15:0] src_reg = (g < LPFA_FILT_PER_REG) ? act_low_reg : act_high_reg;
      assign filt_act[g] = src_reg[BASE + LPFA_ACT_LSB +: 2];
      assign filt_pri[g] = src_reg[BASE + LPFA_PRI_LSB +: 2];
   end

   function automatic logic [2:0] lowest_set(input logic [7:0] v);
      lowest_set = 3'h0;
      for (int i = LPFA_NUM_FILT - 1; i >= 0; i--) begin
         if (v[i]) begin
            lowest_set = 3'(i);
         end
      end
   endfunction : lowest_set

   wire logic [1:0] comp_sel = ctrl_reg[LPFA_COMP_LSB +: 2];
   wire logic [5:0] prec_vec = ctrl_reg[LPFA_PREC_LSB +: LPFA_NUM_PORTS];
   wire logic [5:0] prien_vec = ctrl_reg[LPFA_PRIEN_LSB +: LPFA_NUM_PORTS];
   wire logic [7:0] cand = (comp_sel == LPFA_COMP_OFF) ? 8'h00 :
                           (comp_sel == LPFA_COMP_DST) ? FRM_REQ_I.dst_match :
                           (comp_sel == LPFA_COMP_SRC) ? FRM_REQ_I.src_match :
                           (FRM_REQ_I.dst_match | FRM_REQ_I.src_match);
   wire logic l4_hit = |cand;
   wire logic [2:0] sel_idx = lowest_set(cand);
   wire logic [1:0] sel_act = filt_act[sel_idx];
   wire logic [1:0] sel_pri = filt_pri[sel_idx];
   wire logic port_ok = (FRM_REQ_I.ingress_port < 3'(LPFA_NUM_PORTS));
   // ingress numbers beyond the last port select no per-port option
   wire logic port_prec = port_ok && prec_vec[FRM_REQ_I.ingress_port];
   wire logic port_prien = port_ok && prien_vec[FRM_REQ_I.ingress_port];
   wire logic [5:0] cpu_bit = 6'h01 << CPU_PORT;
   wire logic from_cpu = (FRM_REQ_I.ingress_port == CPU_PORT);
   wire logic [5:0] no_cpu_map = FRM_REQ_I.default_ports & ~cpu_bit;
   wire logic [5:0] l4_map = (sel_act == LPFA_ACT_DEFAULT) ? FRM_REQ_I.default_ports :
                             (sel_act == LPFA_ACT_DROP) ? 6'h00 :
                             (sel_act == LPFA_ACT_TO_CPU) ? (from_cpu ? no_cpu_map : cpu_bit) :
                             no_cpu_map;
   wire logic use_ip = FRM_REQ_I.ip_hit && l4_hit && port_prec;

   lpfa_res_type res_next;
   lpfa_res_type res_reg;

   always_comb begin
      res_next = '0;
      res_next.valid = FRM_REQ_I.valid;
      res_next.l4_hit = l4_hit;
      res_next.use_ip = use_ip;
      res_next.filter = sel_idx;
      if (use_ip) begin
         res_next.ports = FRM_REQ_I.ip_ports;
         res_next.queue_en = 1'b1;
         res_next.queue = FRM_REQ_I.ip_queue;
      end else if (l4_hit) begin
         res_next.ports = l4_map;
         res_next.queue_en = port_prien;
         res_next.queue = port_prien ? sel_pri : 2'h0;
      end else begin
         res_next.ports = FRM_REQ_I.default_ports;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         res_reg <= '0;
      end else begin
         res_reg <= res_next;
      end
   end

   assign FRM_RES_O = res_reg;

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!rst_n_reg);

   AST_ACT_DEFAULT: assert property ($past(FRM_REQ_I.valid && l4_hit && !use_ip && sel_act == LPFA_ACT_DEFAULT)
      |-> FRM_RES_O.ports == $past(FRM_REQ_I.default_ports)) else $error("action 00 map wrong");
   AST_ACT_DROP: assert property ($past(FRM_REQ_I.valid && l4_hit && !use_ip && sel_act == LPFA_ACT_DROP)
      |-> FRM_RES_O.ports == 6'h00) else $error("action 01 map not zero");
   AST_ACT_CPU: assert property ($past(FRM_REQ_I.valid && l4_hit && !use_ip && sel_act == LPFA_ACT_TO_CPU && !from_cpu)
      |-> FRM_RES_O.ports == cpu_bit) else $error("action 10 not cpu only");
   AST_ACT_NOCPU: assert property ($past(FRM_REQ_I.valid && l4_hit && !use_ip && sel_act == LPFA_ACT_NO_CPU)
      |-> (FRM_RES_O.ports & cpu_bit) == 6'h00) else $error("action 11 kept cpu port");
   // the queue is taken from the filter selected in the request cycle, not from today's result index
   AST_QUEUE: assert property (FRM_RES_O.valid && FRM_RES_O.l4_hit && !FRM_RES_O.use_ip && FRM_RES_O.queue_en
      |-> FRM_RES_O.queue == $past(sel_pri)) else $error("queue not from filter");
   AST_WR_LOW: assert property (wr_low && w_strb_reg == 2'h3 |=> act_low_reg == $past(w_data_reg))
      else $error("low action register not written");
   AST_WR_HIGH: assert property (wr_high && w_strb_reg == 2'h3 |=> act_high_reg == $past(w_data_reg))
      else $error("high action register not written");
   AST_COMP_OFF: assert property (comp_sel == LPFA_COMP_OFF |=> !FRM_RES_O.l4_hit)
      else $error("hit while compare disabled");
   AST_IP_WINS: assert property ($past(FRM_REQ_I.valid && FRM_REQ_I.ip_hit && l4_hit && port_prec)
      |-> FRM_RES_O.ports == $past(FRM_REQ_I.ip_ports)) else $error("ip result not applied");
   AST_PRIEN: assert property ($past(l4_hit && !use_ip && !port_prien) |-> !FRM_RES_O.queue_en)
      else $error("l4 priority used while off");
   AST_LOWEST: assert property (FRM_RES_O.l4_hit |-> ($past(cand) & ((8'h01 << FRM_RES_O.filter) - 8'h01)) == 8'h00)
      else $error("not lowest filter");
   AST_BRESP: assert property (wr_go |=> S_AXI_BVALID_O) else $error("no write response");

   // frame result checks beyond the action codes
   AST_DEFAULT_MISS: assert property ($past(FRM_REQ_I.valid && !l4_hit) |-> !FRM_RES_O.queue_en)
      else $error("queue enabled without a hit");
   AST_MISS_PORTS: assert property ($past(!l4_hit) |-> FRM_RES_O.ports == $past(FRM_REQ_I.default_ports))
      else $error("miss did not keep default ports");
   AST_CPU_FROM_CPU: assert property ($past(l4_hit && !use_ip && sel_act == LPFA_ACT_TO_CPU && from_cpu)
      |-> FRM_RES_O.ports == $past(no_cpu_map)) else $error("action 10 from cpu map wrong");
   AST_NOCPU_MAP: assert property ($past(l4_hit && !use_ip && sel_act == LPFA_ACT_NO_CPU)
      |-> FRM_RES_O.ports == $past(no_cpu_map)) else $error("action 11 map wrong");
   AST_QUEUE_OFF: assert property (!FRM_RES_O.queue_en |-> FRM_RES_O.queue == 2'h0)
      else $error("queue nonzero while unused");
   AST_PRIEN_ON: assert property ($past(l4_hit && !use_ip && port_prien) |-> FRM_RES_O.queue_en)
      else $error("l4 priority ignored while on");
   AST_TCP_WINS: assert property ($past(FRM_REQ_I.ip_hit && l4_hit && !port_prec) |-> !FRM_RES_O.use_ip)
      else $error("ip result used while l4 wins");
   AST_FILT_NONE: assert property ($past(!l4_hit) |-> FRM_RES_O.filter == 3'h0)
      else $error("filter index without a hit");
   AST_HIT_IN_CAND: assert property (FRM_RES_O.l4_hit |-> $past(cand[sel_idx]))
      else $error("selected filter did not match");
   // filter 0 and filter 7 fields read straight from their registers, independent of the extraction loop
   AST_PRI_LOW: assert property ($past(l4_hit && !use_ip && port_prien && sel_idx == 3'h0)
      |-> FRM_RES_O.queue == $past(act_low_reg[1:0])) else $error("filter 0 priority misplaced");
   AST_ACT_HIGH7: assert property ($past(l4_hit && !use_ip && sel_idx == 3'h7 && act_high_reg[15:14] == 2'h1)
      |-> FRM_RES_O.ports == 6'h00) else $error("filter 7 action misplaced");
   AST_VALID_PIPE: assert property ($past(FRM_REQ_I.valid) |-> FRM_RES_O.valid)
      else $error("result valid lost");

   // register bus checks
   AST_CTRL_RSV: assert property (ctrl_reg[15:14] == 2'h0)
      else $error("reserved control bits set");
   AST_WR_CTRL: assert property (wr_ctrl && w_strb_reg == 2'h3 |=> ctrl_reg == ($past(w_data_reg) & LPFA_CTRL_MASK))
      else $error("control register not written");
   AST_WR_MISS: assert property (wr_go && !wr_hit |=> $stable(act_low_reg) && $stable(act_high_reg) && $stable(ctrl_reg))
      else $error("unmapped write changed a register");
   AST_SLVERR: assert property (wr_go && !wr_hit |=> S_AXI_BRESP_O == LPFA_RESP_SLVERR)
      else $error("unmapped write not refused");
   AST_RD_MISS: assert property (ar_take && !rd_hit |=> S_AXI_RRESP_O == LPFA_RESP_SLVERR && S_AXI_RDATA_O == 32'h0)
      else $error("unmapped read not refused");
   AST_RD_UPPER: assert property (ar_take |=> S_AXI_RVALID_O && S_AXI_RDATA_O[31:16] == 16'h0000)
      else $error("read answer wrong");
   AST_BVALID_HOLD: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
      else $error("write response dropped");
   AST_RVALID_HOLD: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
      else $error("read response dropped");
   // a held half must not be overwritten before the write commits
   AST_AW_HOLD: assert property (aw_hold_reg && !wr_go |=> !S_AXI_AWREADY_O)
      else $error("address accepted while one is held");
   AST_W_HOLD: assert property (w_hold_reg && !wr_go |=> !S_AXI_WREADY_O)
      else $error("data accepted while one is held");

   COV_DROP: cover property (FRM_RES_O.valid && FRM_RES_O.l4_hit && FRM_RES_O.ports == 6'h00);
   COV_IP: cover property (FRM_RES_O.valid && FRM_RES_O.use_ip);
   COV_MULTI: cover property ($past(FRM_REQ_I.valid) && $countones($past(cand)) > 1);
   COV_ERR: cover property (S_AXI_RVALID_O && S_AXI_RRESP_O == LPFA_RESP_SLVERR);
   COV_TO_CPU: cover property (FRM_RES_O.valid && FRM_RES_O.l4_hit && FRM_RES_O.ports == cpu_bit);

endmodule : lpfa_top

/* File: verification/tb_top.sv */
// self-checking testbench for the l4 port filter action block
`timescale 1ns/1ps
module tb_top
   import lpfa_pkg::*;
;
   typedef struct packed {
      logic [15:0] lo;
      logic [15:0] ctrl;
      logic [15:0] hi;
      lpfa_req_type req;
      lpfa_res_type exp;
   } lpfa_row_type;
   localparam logic [11:0] A_LO = {LPFA_IDX_ACT_LOW, 2'b00};
   localparam logic [11:0] A_HI = {LPFA_IDX_ACT_HIGH, 2'b00};
   localparam logic [11:0] A_CT = {LPFA_IDX_CTRL, 2'b00};
   // whole run needs well under a thousand cycles
   localparam int LIMIT = 4000;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [11:0] aw_addr = '0, ar_addr = '0;
   logic aw_valid = 1'b0, w_valid = 1'b0, ar_valid = 1'b0;
   logic [31:0] w_data = '0;
   logic [3:0] w_strb = '0;
   // always ready: answers are taken at the edge they appear
   logic b_ready = 1'b1, r_ready = 1'b1;
   logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
   logic [1:0] b_resp, r_resp;
   logic [31:0] r_data;
   lpfa_req_type frm_req = '0;
   lpfa_res_type frm_res;
   lpfa_row_type rows [$];
   int mismatches = 0, comparisons = 0, cycles = 0;

   lpfa_top #(.CPU_PORT(3'h5)) dut (
      .SYS_CLK_I(sys_clk), .RSTN_I(rstn),
      .S_AXI_AWADDR_I(aw_addr), .S_AXI_AWVALID_I(aw_valid), .S_AXI_AWREADY_O(aw_ready),
      .S_AXI_WDATA_I(w_data), .S_AXI_WSTRB_I(w_strb), .S_AXI_WVALID_I(w_valid), .S_AXI_WREADY_O(w_ready),
      .S_AXI_BRESP_O(b_resp), .S_AXI_BVALID_O(b_valid), .S_AXI_BREADY_I(b_ready),
      .S_AXI_ARADDR_I(ar_addr), .S_AXI_ARVALID_I(ar_valid), .S_AXI_ARREADY_O(ar_ready),
      .S_AXI_RDATA_O(r_data), .S_AXI_RRESP_O(r_resp), .S_AXI_RVALID_O(r_valid), .S_AXI_RREADY_I(r_ready),
      .FRM_REQ_I(frm_req), .FRM_RES_O(frm_res)
   );

   always #2.5 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         mismatches++;
         $display("timeout at t=%0t", $time);
         summarize();
      end
   end

   task automatic summarize();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   task automatic chk32(input logic [31:0] act, input logic [31:0] exp);
      comparisons++;
      if (act !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
      end
   endtask : chk32

   task automatic chk_res(input lpfa_res_type act, input lpfa_res_type exp);
      comparisons++;
      if (act !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
      end
   endtask : chk_res

   task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] s, input logic [1:0] er);
      aw_addr <= a;
      aw_valid <= 1'b1;
      w_data <= {16'h0000, d};
      w_strb <= {2'b00, s};
      w_valid <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (aw_ready === 1'b1) aw_valid <= 1'b0;
         if (w_ready === 1'b1) w_valid <= 1'b0;
      end while (b_valid !== 1'b1);
      chk32({30'h0, b_resp}, {30'h0, er});
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [15:0] ed, input logic [1:0] er);
      ar_addr <= a;
      ar_valid <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (ar_ready === 1'b1) ar_valid <= 1'b0;
      end while (r_valid !== 1'b1);
      chk32(r_data, {16'h0000, ed});
      chk32({30'h0, r_resp}, {30'h0, er});
   endtask : rd

   task automatic frame(input lpfa_req_type r, input lpfa_res_type e);
      frm_req <= r;
      @(posedge sys_clk);
      frm_req <= '0;
      #1;
      chk_res(frm_res, e);
   endtask : frame

   function automatic lpfa_req_type rq(input logic [2:0] ing, input logic [5:0] dp, input logic [7:0] sm,
      input logic [7:0] dm, input logic iph = 1'b0, input logic [5:0] ipp = 6'h00, input logic [1:0] ipq = 2'h0);
      return {1'b1, ing, dp, sm, dm, iph, ipp, ipq};
   endfunction : rq

   function automatic lpfa_res_type rs(input logic h, input logic u, input logic [2:0] f, input logic [5:0] p,
      input logic qe, input logic [1:0] q);
      return {1'b1, h, u, f, p, qe, q};
   endfunction : rs

   function automatic void add(input logic [15:0] lo, input logic [15:0] ct, input lpfa_req_type r,
      input lpfa_res_type e, input logic [15:0] hi = 16'h0000);
      rows.push_back('{lo, ct, hi, r, e});
   endfunction : add

   initial begin
      add(16'h0003, 16'h1001, rq(3'h0, 6'h2A, 8'h00, 8'h01), rs(1'b1, 1'b0, 3'h0, 6'h2A, 1'b1, 2'h3));
      add(16'h0005, 16'h1000, rq(3'h0, 6'h2A, 8'h00, 8'h01), rs(1'b1, 1'b0, 3'h0, 6'h00, 1'b0, 2'h0));
      add(16'h0008, 16'h1000, rq(3'h1, 6'h1F, 8'h00, 8'h01), rs(1'b1, 1'b0, 3'h0, 6'h20, 1'b0, 2'h0));
      add(16'h0008, 16'h1000, rq(3'h5, 6'h3F, 8'h00, 8'h01), rs(1'b1, 1'b0, 3'h0, 6'h1F, 1'b0, 2'h0));
      add(16'h000C, 16'h1000, rq(3'h2, 6'h3F, 8'h00, 8'h01), rs(1'b1, 1'b0, 3'h0, 6'h1F, 1'b0, 2'h0));
      add(16'h0004, 16'h2000, rq(3'h0, 6'h15, 8'h01, 8'h00), rs(1'b1, 1'b0, 3'h0, 6'h00, 1'b0, 2'h0));
      add(16'h0004, 16'h2000, rq(3'h0, 6'h15, 8'h00, 8'h01), rs(1'b0, 1'b0, 3'h0, 6'h15, 1'b0, 2'h0));
      add(16'h0004, 16'h0000, rq(3'h0, 6'h15, 8'h01, 8'h01), rs(1'b0, 1'b0, 3'h0, 6'h15, 1'b0, 2'h0));
      add(16'h0044, 16'h3000, rq(3'h0, 6'h15, 8'h02, 8'h00), rs(1'b1, 1'b0, 3'h1, 6'h00, 1'b0, 2'h0));
      add(16'hD060, 16'h1001, rq(3'h0, 6'h3F, 8'h00, 8'h0A), rs(1'b1, 1'b0, 3'h1, 6'h00, 1'b1, 2'h2));
      add(16'hD060, 16'h1008, rq(3'h3, 6'h3F, 8'h00, 8'h08), rs(1'b1, 1'b0, 3'h3, 6'h1F, 1'b1, 2'h1));
      add(16'h0000, 16'h1010, rq(3'h4, 6'h3F, 8'h00, 8'h80), rs(1'b1, 1'b0, 3'h7, 6'h00, 1'b1, 2'h3), 16'h7000);
      add(16'h000C, 16'h1200, rq(3'h3, 6'h3F, 8'h00, 8'h01, 1'b1, 6'h11, 2'h2),
         rs(1'b1, 1'b1, 3'h0, 6'h11, 1'b1, 2'h2));
      add(16'h000C, 16'h1000, rq(3'h3, 6'h3F, 8'h00, 8'h01, 1'b1, 6'h11, 2'h2),
         rs(1'b1, 1'b0, 3'h0, 6'h1F, 1'b0, 2'h0));
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      foreach (rows[i]) begin
         wr(A_LO, rows[i].lo, 2'h3, LPFA_RESP_OKAY);
         wr(A_HI, rows[i].hi, 2'h3, LPFA_RESP_OKAY);
         wr(A_CT, rows[i].ctrl, 2'h3, LPFA_RESP_OKAY);
         frame(rows[i].req, rows[i].exp);
         $display("row %0d done", i);
      end
      // reserved top bits of the control register never stick
      wr(A_CT, 16'hFFFF, 2'h3, LPFA_RESP_OKAY);
      rd(A_CT, 16'h3FFF, LPFA_RESP_OKAY);
      wr(A_LO, 16'h0000, 2'h3, LPFA_RESP_OKAY);
      wr(A_LO, 16'hABCD, 2'h1, LPFA_RESP_OKAY);
      rd(A_LO, 16'h00CD, LPFA_RESP_OKAY);
      wr(A_LO, 16'hABCD, 2'h2, LPFA_RESP_OKAY);
      rd(A_LO, 16'hABCD, LPFA_RESP_OKAY);
      wr(A_HI, 16'h5A3C, 2'h3, LPFA_RESP_OKAY);
      rd(A_HI, 16'h5A3C, LPFA_RESP_OKAY);
      $display("register access test done");
      wr(12'h264, 16'h1234, 2'h3, LPFA_RESP_SLVERR);
      rd(12'h264, 16'h0000, LPFA_RESP_SLVERR);
      rd(A_LO + 12'h002, 16'h0000, LPFA_RESP_SLVERR);
      rd(A_LO, 16'hABCD, LPFA_RESP_OKAY);
      $display("unmapped access test done");
      // second reset in mid-run with nonzero registers
      rstn <= 1'b0;
      #1;
      chk_res(frm_res, '0);
      chk32({29'h0, aw_ready, w_ready, ar_ready}, 32'h00000007);
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(A_LO, LPFA_RST_ACT, LPFA_RESP_OKAY);
      rd(A_HI, LPFA_RST_ACT, LPFA_RESP_OKAY);
      rd(A_CT, LPFA_RST_CTRL, LPFA_RESP_OKAY);
      $display("reset test done");
      summarize();
   end
endmodule : tb_top
